// >>> hdl/msrb_pkg.sv
// Package for the model-specific register bank: index map, reset values, carriers
package msrb_pkg;

    // ************************************************************
    // Index map
    // ************************************************************
    localparam logic [31:0] IDX_FAULT_ADDRESS   = 32'h0000_0000;
    localparam logic [31:0] IDX_FAULT_TYPE      = 32'h0000_0001;
    localparam logic [31:0] IDX_CACHE_TEST      = 32'h0000_000e;
    localparam logic [31:0] IDX_CYCLE_COUNTER   = 32'h0000_0010;
    localparam logic [31:0] IDX_EXT_FEATURE     = 32'hc000_0080;
    localparam logic [31:0] IDX_FAST_CALL       = 32'hc000_0081;
    localparam logic [31:0] IDX_WRITE_ALLOC     = 32'hc000_0082;
    localparam logic [31:0] IDX_RANGE_CACHE     = 32'hc000_0085;
    localparam logic [31:0] IDX_POWER_MGMT      = 32'hc000_0086;
    localparam logic [31:0] IDX_STATE_OBSERVE   = 32'hc000_0087;
    localparam logic [31:0] IDX_PAGE_FLUSH      = 32'hc000_0088;
    localparam logic [31:0] IDX_L2_ARRAY        = 32'hc000_0089;

    // ************************************************************
    // Reset values and control bit position
    // ************************************************************
    localparam logic [63:0] RST_FAULT_CAPTURE   = 64'h0;
    localparam logic [63:0] RST_OTHER           = 64'h0;
    localparam logic [31:0] RST_CTRL_FOUR       = 32'h0;
    localparam int          FAULT_CHECK_EN_BIT  = 6;
    localparam int          NUM_REGS            = 12;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] index;
        logic [31:0] high;
        logic [31:0] low;
    } msrb_req_s;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic [31:0] high;
        logic [31:0] low;
    } msrb_rsp_s;

endpackage : msrb_pkg

// >>> hdl/msrb_bank.sv
// Model-specific register bank with index decode and fault capture registers
`timescale 1ns/1ps

// Function
// - Index register selects accessed register
// - Data pairs in high and low halves
// - Eleven registers, twelve on low-power builds
// - Power register decoded only on low-power
// - Decode test, counter, feature, C000_0081h-82h, 85h-89h
// - Fault address 00h, fault type 01h
// - Fault registers 64-bit read/write
// - Never raise fault check exception; store enable bit
// - Fault registers change only write/reset
// - No hardware event updates fault registers
module msrb_bank #(
    parameter bit LOW_POWER = 1'b0
) (
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire msrb_pkg::msrb_req_s req,
    output msrb_pkg::msrb_rsp_s      rsp,
    input  wire logic                ctrl_four_wr,
    input  wire logic [31:0]         ctrl_four_wdata,
    output logic [31:0]              control_register_four,
    output logic                     fault_check_enable,
    output logic                     fault_check_exception
);

    // ************************************************************
    // Index decode
    // ************************************************************
    localparam int N = msrb_pkg::NUM_REGS;
    localparam logic [31:0] IDX_TABLE [N] = '{
        msrb_pkg::IDX_FAULT_ADDRESS, msrb_pkg::IDX_FAULT_TYPE,
        msrb_pkg::IDX_CACHE_TEST,    msrb_pkg::IDX_CYCLE_COUNTER,
        msrb_pkg::IDX_EXT_FEATURE,   msrb_pkg::IDX_FAST_CALL,
        msrb_pkg::IDX_WRITE_ALLOC,   msrb_pkg::IDX_RANGE_CACHE,
        msrb_pkg::IDX_POWER_MGMT,    msrb_pkg::IDX_STATE_OBSERVE,
        msrb_pkg::IDX_PAGE_FLUSH,    msrb_pkg::IDX_L2_ARRAY
    };
    localparam int PM_SLOT = 8;

    logic [N-1:0]  hit;
    logic [63:0]   bank_reg [N];
    logic [63:0]   rd_mux;
    logic          any_hit;
    logic          access;
    msrb_pkg::msrb_rsp_s rsp_reg;
    logic [31:0]   ctrl_four_reg;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_slot
            if (g == PM_SLOT) begin : g_pm
                assign hit[g] = LOW_POWER && (req.index == IDX_TABLE[g]);
            end else begin : g_std
                assign hit[g] = (req.index == IDX_TABLE[g]);
            end

            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    bank_reg[g] <= (g < 2) ? msrb_pkg::RST_FAULT_CAPTURE : msrb_pkg::RST_OTHER;
                end else if (req.wr && hit[g]) begin
                    bank_reg[g] <= {req.high, req.low};
                end
            end
        end
    endgenerate

    assign any_hit = |hit;
    assign access  = req.rd | req.wr;

    always_comb begin
        rd_mux = 64'h0;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                rd_mux = bank_reg[i];
            end
        end
    end

    // ************************************************************
    // Response
    // ************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.done <= access;
            rsp_reg.fault <= access && !any_hit;
            if (req.rd && any_hit) begin
                rsp_reg.high <= rd_mux[63:32];
                rsp_reg.low  <= rd_mux[31:0];
            end
        end
    end
    assign rsp = rsp_reg;

    // ************************************************************
    // Control register four
    // ************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_four_reg <= msrb_pkg::RST_CTRL_FOUR;
        end else if (ctrl_four_wr) begin
            ctrl_four_reg <= ctrl_four_wdata;
        end
    end
    assign control_register_four = ctrl_four_reg;
    assign fault_check_enable    = ctrl_four_reg[msrb_pkg::FAULT_CHECK_EN_BIT];
    assign fault_check_exception = 1'b0;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_WRITE_STORES: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.wr && hit[0] |=> bank_reg[0] == $past({req.high, req.low}))
        else $error("fault address write not stored");
    AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.rd && hit[3] |=> {rsp.high, rsp.low} == $past(bank_reg[3]))
        else $error("read data mismatch");
    AST_PM_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_POWER_MGMT) |-> hit[PM_SLOT] == LOW_POWER)
        else $error("power slot decode wrong for variant");
    AST_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $countones(hit) <= 1)
        else $error("more than one slot hit");
    AST_DECODE_TYPE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_FAULT_TYPE) |-> hit == 12'h002)
        else $error("fault type decode wrong");
    AST_DECODE_FEATURE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_EXT_FEATURE) |-> hit == 12'h010)
        else $error("feature decode wrong");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(req.wr && hit[1]) |=> $stable(bank_reg[1]))
        else $error("fault type changed without write");
    AST_NO_EXC: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fault_check_enable |-> !fault_check_exception)
        else $error("fault exception raised");
    AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        access && !any_hit |=> rsp.fault && rsp.done ##0 $stable(bank_reg[0]))
        else $error("unmapped access not faulted");
    AST_ADDR_FULL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.rd && hit[0] |=> rsp.high == $past(bank_reg[0][63:32]))
        else $error("fault address high half lost");
    AST_NO_HW: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !req.wr |=> $stable(bank_reg[0]) && $stable(bank_reg[1]))
        else $error("fault register changed by hardware");

    // ************************************************************
    // Decode checks per index
    // ************************************************************
    AST_DECODE_ADDR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_FAULT_ADDRESS) |-> hit == 12'h001)
        else $error("fault address decode wrong");
    AST_DECODE_TEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_CACHE_TEST) |-> hit == 12'h004)
        else $error("cache test decode wrong");
    AST_DECODE_COUNTER: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_CYCLE_COUNTER) |-> hit == 12'h008)
        else $error("cycle counter decode wrong");
    AST_DECODE_FAST_CALL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_FAST_CALL) |-> hit == 12'h020)
        else $error("fast call decode wrong");
    AST_DECODE_WRITE_ALLOC: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_WRITE_ALLOC) |-> hit == 12'h040)
        else $error("write allocate decode wrong");
    AST_DECODE_RANGE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_RANGE_CACHE) |-> hit == 12'h080)
        else $error("range cacheability decode wrong");
    AST_DECODE_OBSERVE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_STATE_OBSERVE) |-> hit == 12'h200)
        else $error("state observation decode wrong");
    AST_DECODE_FLUSH: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_PAGE_FLUSH) |-> hit == 12'h400)
        else $error("page flush decode wrong");
    AST_DECODE_ARRAY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.index == msrb_pkg::IDX_L2_ARRAY) |-> hit == 12'h800)
        else $error("array access decode wrong");

    // ************************************************************
    // Storage and response checks
    // ************************************************************
    AST_TYPE_STORES: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.wr && hit[1] |=> bank_reg[1] == $past({req.high, req.low}))
        else $error("fault type write not stored");
    AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(req.wr && hit[0]) |=> $stable(bank_reg[0]))
        else $error("fault address changed without write");
    AST_DONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        access |=> rsp.done)
        else $error("access not answered");
    AST_NO_DONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !access |=> !rsp.done && !rsp.fault)
        else $error("answer without access");
    AST_READ_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(req.rd && any_hit) |=> $stable({rsp.high, rsp.low}))
        else $error("read data moved without mapped read");
    // Standard build must refuse the power index without touching its slot
    AST_PM_REFUSED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        req.wr && (req.index == msrb_pkg::IDX_POWER_MGMT) && !LOW_POWER
        |=> $stable(bank_reg[PM_SLOT]))
        else $error("power slot written on standard build");

endmodule : msrb_bank

// >>> bench/msrb_core_model.sv
// Execution core model issuing register read and write requests
`timescale 1ns/1ps
module msrb_core_model (
    output msrb_pkg::msrb_req_s req
);
    initial req = '0;
    // Caller times requests on falling edges; idle is all zero
    task automatic drive(input logic rd, input logic wr, input logic [31:0] idx,
                         input logic [63:0] d);
        req = {rd, wr, idx, d};
    endtask : drive
endmodule : msrb_core_model

// >>> bench/msrb_bank_tb.sv
// Self-checking bench for the register bank against an associative-array model
`timescale 1ns/1ps
module msrb_bank_tb;
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    logic                ctrl_four_wr = 1'b0;
    logic [31:0]         ctrl_four_wdata = 32'h0;
    logic [31:0]         control_register_four;
    logic                fault_check_enable;
    logic                fault_check_exception;
    msrb_pkg::msrb_req_s req;
    msrb_pkg::msrb_rsp_s rsp;
    msrb_pkg::msrb_rsp_s rsp_lp;
    logic [31:0]         cr4_lp;
    logic                fce_lp;
    logic                exc_lp;
    logic [63:0]         pm_val;
    logic [63:0]         last_lp;
    int                  bad_count = 0;
    int                  checks_done = 0;
    int                  cycles = 0;
    int                  seed = 32'h1c76;
    int                  k;
    logic [63:0]         mem [logic [31:0]];
    logic [63:0]         last;
    logic [31:0]         idx;
    logic [31:0]         map_q [11] = '{msrb_pkg::IDX_FAULT_ADDRESS,
        msrb_pkg::IDX_FAULT_TYPE, msrb_pkg::IDX_CACHE_TEST, msrb_pkg::IDX_CYCLE_COUNTER,
        msrb_pkg::IDX_EXT_FEATURE, msrb_pkg::IDX_FAST_CALL, msrb_pkg::IDX_WRITE_ALLOC,
        msrb_pkg::IDX_RANGE_CACHE, msrb_pkg::IDX_STATE_OBSERVE, msrb_pkg::IDX_PAGE_FLUSH,
        msrb_pkg::IDX_L2_ARRAY};

    initial forever #12.5 clk_sys = ~clk_sys;

    msrb_core_model core (.req(req));
    // Standard-power build: power index must refuse
    msrb_bank #(.LOW_POWER(1'b0)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
        .rsp(rsp), .ctrl_four_wr(ctrl_four_wr), .ctrl_four_wdata(ctrl_four_wdata),
        .control_register_four(control_register_four),
        .fault_check_enable(fault_check_enable),
        .fault_check_exception(fault_check_exception));
    // Low-power build shares the request: power index must answer
    msrb_bank #(.LOW_POWER(1'b1)) DUT_LP (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
        .rsp(rsp_lp), .ctrl_four_wr(ctrl_four_wr), .ctrl_four_wdata(ctrl_four_wdata),
        .control_register_four(cr4_lp),
        .fault_check_enable(fce_lp),
        .fault_check_exception(exc_lp));

    task automatic results;
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic clr;
        foreach (map_q[i]) mem[map_q[i]] = 64'h0;
        last = 64'h0;
        pm_val = 64'h0;
        last_lp = 64'h0;
    endtask : clr

    // Back to back: next request is raised at the edge where this one is checked
    task automatic op(input logic wr, input logic [31:0] ix, input logic [63:0] d);
        logic hit;
        logic pm;
        hit = mem.exists(ix);
        pm = (ix == msrb_pkg::IDX_POWER_MGMT);
        core.drive(!wr, wr, ix, d);
        @(negedge clk_sys);
        chk("done", 64'h1, {63'h0, rsp.done});
        chk("fault", {63'h0, !hit}, {63'h0, rsp.fault});
        if (hit && wr) mem[ix] = d;
        if (hit && !wr) last = mem[ix];
        if (hit && !wr) last_lp = mem[ix];
        if (pm && wr) pm_val = d;
        if (pm && !wr) last_lp = pm_val;
        chk("rdata", last, {rsp.high, rsp.low});
        chk("lp_done", 64'h1, {63'h0, rsp_lp.done});
        chk("lp_fault", {63'h0, !(hit || pm)}, {63'h0, rsp_lp.fault});
        chk("lp_rdata", last_lp, {rsp_lp.high, rsp_lp.low});
        chk("exception", 64'h0, {63'h0, fault_check_exception});
    endtask : op

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        clr();
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        foreach (map_q[i]) op(1'b0, map_q[i], 64'h0);
        for (int n = 0; n < 400; n++) begin
            k = $unsigned($random(seed)) % 14;
            idx = k < 11 ? map_q[k] : k == 11 ? msrb_pkg::IDX_POWER_MGMT : $random(seed);
            if (k == 12) idx = 32'h0000_0002;
            op(1'($random(seed)), idx, {$random(seed), $random(seed)});
        end
        foreach (map_q[i]) op(1'b0, map_q[i], 64'h5a);
        op(1'b1, msrb_pkg::IDX_POWER_MGMT, 64'h1234_5678_9abc_def0);
        op(1'b0, msrb_pkg::IDX_POWER_MGMT, 64'h0);
        op(1'b1, msrb_pkg::IDX_FAULT_TYPE, 64'hffff_ffff_ffff_ffff);
        core.drive(1'b0, 1'b0, 32'h0, 64'h0);
        // Mid-run reset must clear both capture registers
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        clr();
        op(1'b0, msrb_pkg::IDX_FAULT_TYPE, 64'h0);
        op(1'b0, msrb_pkg::IDX_FAULT_ADDRESS, 64'h0);
        core.drive(1'b0, 1'b0, 32'h0, 64'h0);
        for (int n = 0; n < 4; n++) begin
            ctrl_four_wr = 1'b1;
            ctrl_four_wdata = $random(seed) ^ (n[0] << 6);
            @(negedge clk_sys);
            ctrl_four_wr = 1'b0;
            @(negedge clk_sys);
            chk("ctrl4", {32'h0, ctrl_four_wdata}, {32'h0, control_register_four});
            chk("fce", {63'h0, ctrl_four_wdata[6]}, {63'h0, fault_check_enable});
        end
        results();
    end
endmodule : msrb_bank_tb
